// >>> logic/rule_match_pkg.sv
// Shared constants for the first classifier stage rule matching memory.
package rule_match_pkg;
    // Geometry of one memory address and of the widest rule.
    localparam int ENTRY_W = 36;
    localparam int ACTION_W = 70;
    localparam int CNT_W = 1;
    localparam int DATA_W = 32;
    localparam int ENTRY_HI_W = ENTRY_W - DATA_W;
    localparam int ACTION_HI_W = ACTION_W - 2 * DATA_W;
    localparam int MAX_RULE_WORDS = 16;
    localparam int OFFSET_W = 4;
    localparam int TG_MAX_W = 5;
    localparam int KEY_W = MAX_RULE_WORDS * ENTRY_W;
    localparam int BLOCK_ADDRS = 4096;
    localparam int DEFAULT_RULES = 114;

    // Register indices on the plain register port.
    localparam int REG_ADDR_W = 4;
    localparam logic [3:0] REG_ENTRY_LO = 4'h0;
    localparam logic [3:0] REG_ENTRY_HI = 4'h1;
    localparam logic [3:0] REG_MASK_LO = 4'h2;
    localparam logic [3:0] REG_MASK_HI = 4'h3;
    localparam logic [3:0] REG_ACTION_0 = 4'h4;
    localparam logic [3:0] REG_ACTION_1 = 4'h5;
    localparam logic [3:0] REG_ACTION_2 = 4'h6;
    localparam logic [3:0] REG_COUNTER = 4'h7;
    localparam logic [3:0] REG_UPDATE_CTRL = 4'h8;
    localparam logic [3:0] REG_UPDATE_ADDR = 4'h9;
    localparam logic [3:0] REG_RANGE_COUNT = 4'ha;
    localparam logic [3:0] REG_LOOKUP_CTRL = 4'hb;
    localparam logic [3:0] REG_STATUS = 4'hc;

    // Field positions in the update control register.
    localparam int CTRL_SHOT_BIT = 0;
    localparam int CTRL_CMD_LSB = 1;
    localparam int CMD_W = 3;
    localparam int CTRL_CLEAR_BIT = 4;
    localparam int CTRL_ENTRY_DIS_BIT = 5;
    localparam int CTRL_ACTION_DIS_BIT = 6;
    localparam int CTRL_CNT_DIS_BIT = 7;

    // Field positions in the lookup control and status registers.
    localparam int LOOKUP_ENA_BIT = 0;
    localparam int STATUS_SHOT_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam int STATUS_DEFAULT_BIT = 2;
    localparam int STATUS_HIT_ADDR_LSB = 16;

    // Cache commands.
    localparam logic [2:0] CMD_WRITE = 3'h0;
    localparam logic [2:0] CMD_READ = 3'h1;
    localparam logic [2:0] CMD_INIT = 3'h4;

    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : rule_match_pkg

// >>> logic/ternary_word_match.sv
// Ternary compare of one key word against one stored entry word.
`timescale 1ns/1ps
module ternary_word_match #(
    parameter int WIDTH = 36
) (
    input wire logic [WIDTH-1:0] data_in,
    input wire logic [WIDTH-1:0] mask_in,
    input wire logic [WIDTH-1:0] key_in,
    output logic hit_out
);
    logic [WIDTH-1:0] bit_ok;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        assign bit_ok[i] = mask_in[i] ? ~data_in[i] : (data_in[i] == key_in[i]);
    end

    assign hit_out = &bit_ok;
endmodule : ternary_word_match

// >>> logic/rule_store.sv
// Entry, mask, action and hit counter arrays with one write and one read port.
`timescale 1ns/1ps
module rule_store #(
    parameter int WORDS = 4210,
    parameter int ADDR_W = 13
) (
    input wire logic sys_clk_in,
    input wire logic [ADDR_W-1:0] waddr_in,
    input wire logic we_entry_in,
    input wire logic we_action_in,
    input wire logic we_cnt_in,
    input wire logic [rule_match_pkg::ENTRY_W-1:0] wr_entry_in,
    input wire logic [rule_match_pkg::ENTRY_W-1:0] wr_mask_in,
    input wire logic [rule_match_pkg::ACTION_W-1:0] wr_action_in,
    input wire logic [rule_match_pkg::CNT_W-1:0] wr_cnt_in,
    input wire logic [ADDR_W-1:0] raddr_in,
    output logic [rule_match_pkg::ENTRY_W-1:0] rd_entry_out,
    output logic [rule_match_pkg::ENTRY_W-1:0] rd_mask_out,
    output logic [rule_match_pkg::ACTION_W-1:0] rd_action_out,
    output logic [rule_match_pkg::CNT_W-1:0] rd_cnt_out
);
    // Contents are not reset; software must initialise every address.
    logic [rule_match_pkg::ENTRY_W-1:0] entry_mem [WORDS];
    logic [rule_match_pkg::ENTRY_W-1:0] mask_mem [WORDS];
    logic [rule_match_pkg::ACTION_W-1:0] action_mem [WORDS];
    logic [rule_match_pkg::CNT_W-1:0] cnt_mem [WORDS];

    always_ff @(posedge sys_clk_in) begin
        if (we_entry_in) begin
            entry_mem[waddr_in] <= wr_entry_in;
            mask_mem[waddr_in] <= wr_mask_in;
        end
        if (we_action_in) begin
            action_mem[waddr_in] <= wr_action_in;
        end
        if (we_cnt_in) begin
            cnt_mem[waddr_in] <= wr_cnt_in;
        end
        rd_entry_out <= entry_mem[raddr_in];
        rd_mask_out <= mask_mem[raddr_in];
        rd_action_out <= action_mem[raddr_in];
        rd_cnt_out <= cnt_mem[raddr_in];
    end
endmodule : rule_store

// >>> logic/rule_match_memory.sv
// First classifier stage rule memory: register cache, commands and key lookup.
`timescale 1ns/1ps
// Operation
// - Default rules are initialised (here by software, as the memory has no reset); enabled lookups apply a default rule on a miss.
// - An Xn item spans n consecutive addresses, each written separately.
// - Rule size is the larger of entry and action address counts.
// - A match increments only the counter at the rule's first address.
// - Disabling goes lowest address first; range initialisation does so.
// - Counters carry no type-group bits.
// - Block of 4096 addresses: 36-bit entry, 70-bit action, one-bit counter.
// - Entry sizes 1, 2, 4, 8, 16; action sizes 1, 2, 4.
// - Data/mask 0/0 match zero, 0/1 any, 1/0 one, 1/1 never.
// - The one-bit hit counter saturates at one.
module rule_match_memory #(
    parameter int DEPTH = rule_match_pkg::BLOCK_ADDRS,
    parameter int DEFAULTS = rule_match_pkg::DEFAULT_RULES,
    parameter int ADDR_W = $clog2(DEPTH + DEFAULTS),
    parameter int DIDX_W = $clog2(DEFAULTS)
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [rule_match_pkg::REG_ADDR_W-1:0] reg_addr_in,
    input wire logic [rule_match_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [rule_match_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic key_valid_in,
    input wire logic [rule_match_pkg::KEY_W-1:0] key_in,
    input wire logic [DIDX_W-1:0] default_index_in,
    output logic key_ready_out,
    output logic result_valid_out,
    output logic result_default_out,
    output logic [ADDR_W-1:0] result_addr_out,
    output logic [rule_match_pkg::ACTION_W-1:0] result_action_out
);
    localparam int EW = rule_match_pkg::ENTRY_W;
    localparam int AW = rule_match_pkg::ACTION_W;
    localparam int DW = rule_match_pkg::DATA_W;
    localparam int OW = rule_match_pkg::OFFSET_W;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_CMD_WRITE = 6'b00_0010,
        ST_CMD_READ = 6'b00_0100,
        ST_SCAN = 6'b00_1000,
        ST_HIT = 6'b01_0000,
        ST_REPORT = 6'b10_0000
    } state_type;

    typedef struct packed {
        state_type state;
        logic [EW-1:0] cache_entry;
        logic [EW-1:0] cache_mask;
        logic [AW-1:0] cache_action;
        logic [rule_match_pkg::CNT_W-1:0] cache_cnt;
        logic shot;
        logic [rule_match_pkg::CMD_W-1:0] cmd;
        logic entry_dis;
        logic action_dis;
        logic cnt_dis;
        logic [ADDR_W-1:0] upd_addr;
        logic [ADDR_W-1:0] range_count;
        logic lookup_ena;
        logic [ADDR_W-1:0] cmd_addr;
        logic [ADDR_W-1:0] cmd_left;
        logic [rule_match_pkg::KEY_W-1:0] key;
        logic [ADDR_W-1:0] default_addr;
        logic [ADDR_W-1:0] scan_addr;
        logic cmp_valid;
        logic [ADDR_W-1:0] cmp_addr;
        logic [ADDR_W-1:0] rule_start;
        logic [OW-1:0] rule_rem;
        logic rule_ok;
        logic is_default;
        logic key_ready;
        logic result_valid;
        logic result_default;
        logic [ADDR_W-1:0] result_addr;
        logic [AW-1:0] result_action;
        logic [DW-1:0] rdata;
    } regs_type;

    regs_type r;
    regs_type next_r;

    logic [EW-1:0] rd_entry;
    logic [EW-1:0] rd_mask;
    logic [AW-1:0] rd_action;
    logic [rule_match_pkg::CNT_W-1:0] rd_cnt;
    logic [ADDR_W-1:0] mem_waddr;
    logic [ADDR_W-1:0] mem_raddr;
    logic we_entry;
    logic we_action;
    logic we_cnt;
    logic [rule_match_pkg::CNT_W-1:0] wr_cnt;
    logic [OW-1:0] seg_off;
    logic [EW-1:0] key_seg;
    logic word_hit;

    // entry size from the one-hot type-group at offset zero
    function automatic logic [OW-1:0] size_minus_one(input logic [EW-1:0] data);
        logic [OW-1:0] n;
        n = '0;
        for (int i = rule_match_pkg::TG_MAX_W - 1; i >= 0; i--) begin
            if (data[i]) begin
                n = OW'((1 << i) - 1);
            end
        end
        return n;
    endfunction : size_minus_one

    assign we_entry = (r.state == ST_CMD_WRITE) && !r.entry_dis;
    assign we_action = (r.state == ST_CMD_WRITE) && !r.action_dis;
    // a hit writes the counter of the first address only
    assign we_cnt = ((r.state == ST_CMD_WRITE) && !r.cnt_dis) || (r.state == ST_HIT);
    // saturate by writing one; counter data taken unaltered
    assign wr_cnt = (r.state == ST_HIT) ? 1'b1 : r.cache_cnt;
    assign mem_waddr = (r.state == ST_HIT) ? r.rule_start : r.cmd_addr;
    assign mem_raddr = (r.state == ST_SCAN) ? r.scan_addr :
                       (r.state == ST_HIT) ? r.rule_start : r.upd_addr;
    assign seg_off = (r.rule_rem == '0) ? '0 : OW'(r.cmp_addr - r.rule_start);
    assign key_seg = r.key[seg_off * EW +: EW];

    rule_store #(
        .WORDS(DEPTH + DEFAULTS),
        .ADDR_W(ADDR_W)
    ) u_store (
        .sys_clk_in(sys_clk_in),
        .waddr_in(mem_waddr),
        .we_entry_in(we_entry),
        .we_action_in(we_action),
        .we_cnt_in(we_cnt),
        .wr_entry_in(r.cache_entry),
        .wr_mask_in(r.cache_mask),
        .wr_action_in(r.cache_action),
        .wr_cnt_in(wr_cnt),
        .raddr_in(mem_raddr),
        .rd_entry_out(rd_entry),
        .rd_mask_out(rd_mask),
        .rd_action_out(rd_action),
        .rd_cnt_out(rd_cnt)
    );

    ternary_word_match #(
        .WIDTH(EW)
    ) u_match (
        .data_in(rd_entry),
        .mask_in(rd_mask),
        .key_in(key_seg),
        .hit_out(word_hit)
    );

    always_comb begin
        logic [OW-1:0] rem;
        logic ok;
        rem = '0;
        ok = 1'b0;
        next_r = r;
        next_r.result_valid = 1'b0;
        next_r.rdata = rule_match_pkg::READ_ZERO;
        unique case (r.state)
            ST_IDLE: begin
                if (r.shot) begin
                    next_r.cmd_addr = r.upd_addr;
                    if (r.cmd == rule_match_pkg::CMD_WRITE) begin
                        next_r.cmd_left = '0;
                        next_r.state = ST_CMD_WRITE;
                    end else if (r.cmd == rule_match_pkg::CMD_INIT) begin
                        next_r.cmd_left = r.range_count;
                        next_r.state = ST_CMD_WRITE;
                    end else if (r.cmd == rule_match_pkg::CMD_READ) begin
                        next_r.state = ST_CMD_READ;
                    end else begin
                        next_r.shot = 1'b0;
                    end
                end else if (key_valid_in && r.key_ready) begin
                    next_r.key = key_in;
                    next_r.default_addr = ADDR_W'(DEPTH) + ADDR_W'(default_index_in);
                    next_r.scan_addr = '0;
                    next_r.cmp_valid = 1'b0;
                    next_r.rule_rem = '0;
                    next_r.state = ST_SCAN;
                end
            end
            ST_CMD_WRITE: begin
                // range fill climbs upward, so the lowest address is disabled first
                if (r.cmd_left == '0) begin
                    next_r.shot = 1'b0;
                    next_r.state = ST_IDLE;
                end else begin
                    next_r.cmd_addr = r.cmd_addr + ADDR_W'(1);
                    next_r.cmd_left = r.cmd_left - ADDR_W'(1);
                end
            end
            ST_CMD_READ: begin
                if (!r.entry_dis) begin
                    next_r.cache_entry = rd_entry;
                    next_r.cache_mask = rd_mask;
                end
                if (!r.action_dis) begin
                    next_r.cache_action = rd_action;
                end
                if (!r.cnt_dis) begin
                    next_r.cache_cnt = rd_cnt;
                end
                next_r.shot = 1'b0;
                next_r.state = ST_IDLE;
            end
            ST_SCAN: begin
                if (r.scan_addr != ADDR_W'(DEPTH)) begin
                    next_r.scan_addr = r.scan_addr + ADDR_W'(1);
                end
                next_r.cmp_valid = (r.scan_addr != ADDR_W'(DEPTH));
                next_r.cmp_addr = r.scan_addr;
                if (r.cmp_valid) begin
                    // surplus entry words are disabled, so the entry size bounds the rule
                    if (r.rule_rem == '0) begin
                        next_r.rule_start = r.cmp_addr;
                        rem = size_minus_one(rd_entry);
                        ok = word_hit;
                    end else begin
                        rem = r.rule_rem - OW'(1);
                        ok = r.rule_ok & word_hit;
                    end
                    next_r.rule_rem = rem;
                    next_r.rule_ok = ok;
                    if (ok && rem == '0) begin
                        next_r.is_default = 1'b0;
                        next_r.state = ST_HIT;
                    end
                end else if (r.scan_addr == ADDR_W'(DEPTH)) begin
                    // miss falls back to the chosen default rule
                    next_r.rule_start = r.default_addr;
                    next_r.is_default = 1'b1;
                    next_r.state = ST_HIT;
                end
            end
            ST_HIT: begin
                next_r.state = ST_REPORT;
            end
            ST_REPORT: begin
                next_r.result_valid = 1'b1;
                next_r.result_default = r.is_default;
                next_r.result_addr = r.rule_start;
                next_r.result_action = rd_action;
                next_r.state = ST_IDLE;
            end
        endcase
        // Software writes land after the hardware clear, so a shot written in the clearing cycle is never lost.
        if (reg_write_in) begin
            unique case (reg_addr_in)
                rule_match_pkg::REG_ENTRY_LO: next_r.cache_entry[DW-1:0] = reg_wdata_in;
                rule_match_pkg::REG_ENTRY_HI: begin
                    next_r.cache_entry[EW-1:DW] = reg_wdata_in[rule_match_pkg::ENTRY_HI_W-1:0];
                end
                rule_match_pkg::REG_MASK_LO: next_r.cache_mask[DW-1:0] = reg_wdata_in;
                rule_match_pkg::REG_MASK_HI: begin
                    next_r.cache_mask[EW-1:DW] = reg_wdata_in[rule_match_pkg::ENTRY_HI_W-1:0];
                end
                rule_match_pkg::REG_ACTION_0: next_r.cache_action[DW-1:0] = reg_wdata_in;
                rule_match_pkg::REG_ACTION_1: next_r.cache_action[2*DW-1:DW] = reg_wdata_in;
                rule_match_pkg::REG_ACTION_2: begin
                    next_r.cache_action[AW-1:2*DW] =
                        reg_wdata_in[rule_match_pkg::ACTION_HI_W-1:0];
                end
                rule_match_pkg::REG_COUNTER: begin
                    next_r.cache_cnt = reg_wdata_in[rule_match_pkg::CNT_W-1:0];
                end
                rule_match_pkg::REG_UPDATE_CTRL: begin
                    next_r.shot = r.shot | reg_wdata_in[rule_match_pkg::CTRL_SHOT_BIT];
                    next_r.cmd =
                        reg_wdata_in[rule_match_pkg::CTRL_CMD_LSB +: rule_match_pkg::CMD_W];
                    next_r.entry_dis = reg_wdata_in[rule_match_pkg::CTRL_ENTRY_DIS_BIT];
                    next_r.action_dis = reg_wdata_in[rule_match_pkg::CTRL_ACTION_DIS_BIT];
                    next_r.cnt_dis = reg_wdata_in[rule_match_pkg::CTRL_CNT_DIS_BIT];
                    // A cleared cache holds a never-matching entry and zero action and count.
                    if (reg_wdata_in[rule_match_pkg::CTRL_CLEAR_BIT]) begin
                        next_r.cache_entry = '1;
                        next_r.cache_mask = '1;
                        next_r.cache_action = '0;
                        next_r.cache_cnt = '0;
                    end
                end
                rule_match_pkg::REG_UPDATE_ADDR: next_r.upd_addr = reg_wdata_in[ADDR_W-1:0];
                rule_match_pkg::REG_RANGE_COUNT: next_r.range_count = reg_wdata_in[ADDR_W-1:0];
                rule_match_pkg::REG_LOOKUP_CTRL: begin
                    next_r.lookup_ena = reg_wdata_in[rule_match_pkg::LOOKUP_ENA_BIT];
                end
                default: ;
            endcase
        end
        if (reg_read_in) begin
            unique case (reg_addr_in)
                rule_match_pkg::REG_ENTRY_LO: next_r.rdata = r.cache_entry[DW-1:0];
                rule_match_pkg::REG_ENTRY_HI: next_r.rdata = DW'(r.cache_entry[EW-1:DW]);
                rule_match_pkg::REG_MASK_LO: next_r.rdata = r.cache_mask[DW-1:0];
                rule_match_pkg::REG_MASK_HI: next_r.rdata = DW'(r.cache_mask[EW-1:DW]);
                rule_match_pkg::REG_ACTION_0: next_r.rdata = r.cache_action[DW-1:0];
                rule_match_pkg::REG_ACTION_1: next_r.rdata = r.cache_action[2*DW-1:DW];
                rule_match_pkg::REG_ACTION_2: next_r.rdata = DW'(r.cache_action[AW-1:2*DW]);
                rule_match_pkg::REG_COUNTER: next_r.rdata = DW'(r.cache_cnt);
                rule_match_pkg::REG_UPDATE_CTRL: begin
                    next_r.rdata[rule_match_pkg::CTRL_SHOT_BIT] = r.shot;
                    next_r.rdata[rule_match_pkg::CTRL_CMD_LSB +: rule_match_pkg::CMD_W] = r.cmd;
                    next_r.rdata[rule_match_pkg::CTRL_ENTRY_DIS_BIT] = r.entry_dis;
                    next_r.rdata[rule_match_pkg::CTRL_ACTION_DIS_BIT] = r.action_dis;
                    next_r.rdata[rule_match_pkg::CTRL_CNT_DIS_BIT] = r.cnt_dis;
                end
                rule_match_pkg::REG_UPDATE_ADDR: next_r.rdata = DW'(r.upd_addr);
                rule_match_pkg::REG_RANGE_COUNT: next_r.rdata = DW'(r.range_count);
                rule_match_pkg::REG_LOOKUP_CTRL: begin
                    next_r.rdata[rule_match_pkg::LOOKUP_ENA_BIT] = r.lookup_ena;
                end
                rule_match_pkg::REG_STATUS: begin
                    next_r.rdata[rule_match_pkg::STATUS_SHOT_BIT] = r.shot;
                    next_r.rdata[rule_match_pkg::STATUS_BUSY_BIT] = (r.state != ST_IDLE);
                    next_r.rdata[rule_match_pkg::STATUS_DEFAULT_BIT] = r.result_default;
                    next_r.rdata[rule_match_pkg::STATUS_HIT_ADDR_LSB +: ADDR_W] = r.result_addr;
                end
                default: ;
            endcase
        end
        // Keys are refused while a cache command is pending or lookups are off.
        next_r.key_ready = (next_r.state == ST_IDLE) && next_r.lookup_ena && !next_r.shot;
    end

    // memory geometry fixed by the cache widths, DEPTH and DEFAULTS
    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            r <= '0;
            r.state <= ST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_out = r.rdata;
    assign key_ready_out = r.key_ready;
    assign result_valid_out = r.result_valid;
    assign result_default_out = r.result_default;
    assign result_addr_out = r.result_addr;
    assign result_action_out = r.result_action;
endmodule : rule_match_memory

// >>> verification/rule_match_memory_chk.sv
// Port checker for the rule matching memory.
`timescale 1ns/1ps
module rule_match_memory_chk #(
    parameter int DEPTH = 32,
    parameter int ADDR_W = 6
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic reg_read_in,
    input wire logic [rule_match_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic key_valid_in,
    input wire logic key_ready_out,
    input wire logic result_valid_out,
    input wire logic result_default_out,
    input wire logic [ADDR_W-1:0] result_addr_out,
    input wire logic [rule_match_pkg::ACTION_W-1:0] result_action_out
);
    // A miss scans every rule address below DEPTH, so the scan length bounds every lookup.
    localparam int MAXW = DEPTH + 8;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);
    rdata_slot_a: assert property (reg_rdata_out != 0 |-> $past(reg_read_in))
        else $error("read data outside its slot");
    key_take_a: assert property (key_valid_in && key_ready_out |=> !key_ready_out)
        else $error("ready stayed high after a key");
    key_bound_a: assert property (key_valid_in && key_ready_out
        |-> ##[2:MAXW] result_valid_out)
        else $error("lookup result late");
    pulse_one_a: assert property (result_valid_out |=> !result_valid_out)
        else $error("result pulse too long");
    ready_back_a: assert property (result_valid_out |=> key_ready_out)
        else $error("ready not back after result");
    busy_result_a: assert property (result_valid_out |-> !$past(key_ready_out))
        else $error("result without a lookup");
    dflt_addr_a: assert property (result_valid_out && result_default_out
        |-> result_addr_out >= DEPTH)
        else $error("default result inside rule area");
    hit_addr_a: assert property (result_valid_out && !result_default_out
        |-> result_addr_out < DEPTH)
        else $error("rule hit outside rule area");
    result_hold_a: assert property (!result_valid_out
        |-> $stable(result_action_out) && $stable(result_addr_out))
        else $error("result changed between pulses");
    cover property (result_valid_out && result_default_out);
    cover property (result_valid_out && !result_default_out);
    cover property (reg_read_in);
endmodule : rule_match_memory_chk

// >>> verification/test_rule_match_memory.sv
// Self-checking bench for the rule matching memory.
`timescale 1ns/1ps
module test_rule_match_memory;
    localparam int DEPTH = 32;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [3:0] reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic reg_write_in = 1'b0;
    logic reg_read_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic key_valid_in = 1'b0;
    logic [575:0] key_in = '0;
    logic [1:0] default_index_in = 2'h0;
    logic key_ready_out;
    logic result_valid_out;
    logic result_default_out;
    logic [5:0] result_addr_out;
    logic [69:0] result_action_out;
    logic [31:0] rv;
    int fail_count = 0;
    int n_checks = 0;
    always #2.5 sys_clk_in = ~sys_clk_in;
    rule_match_memory #(.DEPTH(DEPTH), .DEFAULTS(4)) i_rule_match_memory (
        .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .key_valid_in(key_valid_in), .key_in(key_in),
        .default_index_in(default_index_in), .key_ready_out(key_ready_out),
        .result_valid_out(result_valid_out), .result_default_out(result_default_out),
        .result_addr_out(result_addr_out), .result_action_out(result_action_out));
    task automatic check(input string what, input logic [69:0] seen, input logic [69:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_write_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_read_in <= 1'b0;
        #1 rv = reg_rdata_out;
    endtask : rd
    task automatic cmd(input logic [31:0] a, input logic [31:0] ctrl);
        wr(4'h9, a);
        wr(4'h8, ctrl);
        rv = 32'h0000_0001;
        for (int i = 0; i < 100 && rv[0] !== 1'b0; i++) rd(4'hc);
        check("shot", rv[0], 1'b0);
    endtask : cmd
    task automatic put(input logic [31:0] a, elo, ehi, mlo, mhi, act);
        wr(4'h0, elo);
        wr(4'h1, ehi);
        wr(4'h2, mlo);
        wr(4'h3, mhi);
        wr(4'h4, act);
        cmd(a, 32'h0000_0001);
    endtask : put
    task automatic cnt(input logic [31:0] a, input logic [31:0] exp);
        cmd(a, 32'h0000_0003);
        rd(4'h7);
        check("counter", rv, exp);
    endtask : cnt
    task automatic look(input logic [575:0] k, input logic [1:0] idx, input logic dflt,
                        input logic [5:0] addr, input logic [69:0] act);
        int n;
        @(posedge sys_clk_in);
        key_in <= k;
        default_index_in <= idx;
        key_valid_in <= 1'b1;
        do @(posedge sys_clk_in); while (key_ready_out !== 1'b1);
        key_valid_in <= 1'b0;
        n = 0;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (result_valid_out !== 1'b1 && n < 60);
        check("default flag", result_default_out, dflt);
        check("result addr", result_addr_out, addr);
        check("action", result_action_out, act);
    endtask : look
    task automatic test_regs();
        check("ready at reset", key_ready_out, 1'b0);
        wr(4'h1, 32'hffff_ffff);
        rd(4'h1);
        check("entry high", rv, 32'h0000_000f);
        @(posedge sys_clk_in);
        #1 check("read slot", reg_rdata_out, 32'h0000_0000);
        rd(4'hd);
        check("unmapped", rv, 32'h0000_0000);
        $display("test regs done");
    endtask : test_regs
    task automatic test_bringup();
        wr(4'ha, DEPTH + 3);
        cmd(0, 32'h0000_0019);
        cnt(7, 0);
        rd(4'h0);
        check("disabled entry", rv, 32'hffff_ffff);
        wr(4'h4, 32'h0000_0d05);
        cmd(DEPTH + 2, 32'h0000_00a1);
        wr(4'hb, 32'h0000_0001);
        look('0, 2'h2, 1'b1, DEPTH + 2, 70'h0d05);
        $display("test bringup done");
    endtask : test_bringup
    task automatic test_wide();
        put(5, 0, 0, 32'hffff_fffe, 32'h0000_000f, 0);
        put(4, 32'h0000_0002, 1, 32'hffff_fffc, 32'h0000_000e, 32'h0000_0a51);
        look({540'h0, 36'h1_0000_0002}, 2'h1, 1'b0, 6'h04, 70'h0a51);
        look({540'h0, 36'h1_0000_0002}, 2'h1, 1'b0, 6'h04, 70'h0a51);
        cnt(4, 1);
        cnt(5, 0);
        look({540'h0, 36'h0_0000_0002}, 2'h1, 1'b1, DEPTH + 1, 70'h0);
        look({504'h0, 36'h0_0000_0001, 36'h1_0000_0002}, 2'h3, 1'b1, DEPTH + 3, 70'h0);
        put(11, 0, 0, 32'hffff_fffe, 32'h0000_000f, 0);
        put(10, 0, 0, 32'hffff_fffc, 32'h0000_000f, 0);
        put(9, 0, 0, 32'hffff_fffe, 32'h0000_000f, 32'h0000_0002);
        put(8, 32'h0000_0004, 0, 32'hffff_fff8, 32'h0000_000f, 32'h0000_03c4);
        look(576'h4, 2'h0, 1'b0, 6'h08, 70'h3c4);
        look({432'h0, 36'h1, 72'h0, 36'h4}, 2'h0, 1'b1, DEPTH, 70'h0);
        $display("test wide done");
    endtask : test_wide
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        test_regs();
        test_bringup();
        test_wide();
        report_and_stop();
    end
    // The tests need a few hundred cycles; this margin only cuts a hang.
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        fail_count++;
        report_and_stop();
    end
endmodule : test_rule_match_memory
bind rule_match_memory rule_match_memory_chk #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) i_chk (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .key_valid_in(key_valid_in), .key_ready_out(key_ready_out),
    .result_valid_out(result_valid_out), .result_default_out(result_default_out),
    .result_addr_out(result_addr_out), .result_action_out(result_action_out));
